/* flash_status_config_regs_tb.sv */
// self-checking bench for the flash status/config register bank
`timescale 1ns/1ps
module flash_status_config_regs_tb;
  import fsr_pkg::*;
  // design signals
  logic clk, rst, ce, cmd_valid, cmd_accepted, write_protect_n;
  fsr_cmd_t cmd;
  logic [1:0] cmd_sel, rd_sel, drive_strength;
  logic [7:0] cmd_wdata, rd_data;
  logic [2:0] region, security_lock;
  logic granularity_select, protect_direction, complement_map, quad_enable;
  logic pin_function_select, hold_active, reset_pin_active, high_freq_mode, busy, suspended_flag;
  // bench state
  int err_total, checks, n;
  logic acc;
  logic [7:0] d, v, nv1, q;
  fsr_cmd_t ops [2] = '{FSR_CMD_PROG, FSR_CMD_ERASE};
  int cyc [2] = '{FSR_PROG_CYC + 1, FSR_ERASE_CYC + 1};

  fsr_regs dut (.clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .cmd_accepted(cmd_accepted), .rd_sel(rd_sel), .rd_data(rd_data),
    .write_protect_n(write_protect_n), .region(region), .granularity_select(granularity_select),
    .protect_direction(protect_direction), .complement_map(complement_map), .security_lock(security_lock),
    .quad_enable(quad_enable), .pin_function_select(pin_function_select), .hold_active(hold_active),
    .reset_pin_active(reset_pin_active), .drive_strength(drive_strength), .high_freq_mode(high_freq_mode),
    .busy(busy), .suspended_flag(suspended_flag));
  fsr_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .cmd_accepted(cmd_accepted), .busy(busy));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // expected {reset pin, hold pin}: pin roles vanish when quad is on
  function automatic logic [1:0] pins(logic quad, logic func);
    return {~quad & func, ~quad & ~func};
  endfunction
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // read a register, masked
  task automatic rchk(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e, input string w);
    @(posedge clk);
    rd_sel <= s;
    @(negedge clk);
    chk(rd_data & m, e, w);
  endtask
  // one command; returns mid-cycle so that flags updated by the edge are settled
  task automatic op(input fsr_cmd_t c, input logic [1:0] s, input logic [7:0] dd);
    host.issue(c, s, dd, acc);
    @(negedge clk);
  endtask
  // wait for busy to drop and check its span
  task automatic wait_done(input int hi, input int lo);
    host.poll_idle(hi + 10, n);
    chk(8'(n >= lo && n <= hi), 8'h01, "busy span");
  endtask
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    rd_sel = 2'h0;
    write_protect_n = 1'b1;
    void'($urandom(32'h27A4));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // defaults after reset
    rchk(FSR_SEL_ONE, 8'hFF, FSR_RESET_ONE, "reset one");
    rchk(FSR_SEL_TWO, 8'hFF, FSR_RESET_TWO, "reset two");
    rchk(FSR_SEL_THREE, 8'hFF, FSR_RESET_THREE, "reset three");
    chk({6'h0, reset_pin_active, hold_active}, {6'h0, pins(1'b0, 1'b0)}, "pins reset");
    // latch set and clear
    op(FSR_CMD_WREN, 2'h0, 8'h00);
    rchk(FSR_SEL_ONE, 8'hFF, 8'h02, "latch set");
    op(FSR_CMD_WRDI, 2'h0, 8'h00);
    rchk(FSR_SEL_ONE, 8'hFF, 8'h00, "latch clear");
    // writes and program without the latch do nothing
    op(FSR_CMD_WRSR, FSR_SEL_ONE, 8'h1C);
    op(FSR_CMD_PROG, 2'h0, 8'h00);
    chk({7'h0, busy}, 8'h00, "no start");
    rchk(FSR_SEL_ONE, 8'hFF, 8'h00, "no latch");
    // non-volatile status one write, protect bit clear
    nv1 = 8'($urandom) & 8'h7C;
    op(FSR_CMD_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_ONE, nv1);
    chk({7'h0, busy}, 8'h01, "busy set");
    op(FSR_CMD_WREN, 2'h0, 8'h00);
    chk({7'h0, acc}, 8'h00, "refused while busy");
    op(FSR_CMD_RDSR, 2'h0, 8'h00);
    chk({7'h0, acc}, 8'h01, "status read while busy");
    wait_done(FSR_WRSR_CYC, FSR_WRSR_CYC - 8);
    rchk(FSR_SEL_ONE, 8'hFF, nv1, "nv one");
    chk({1'b0, granularity_select, protect_direction, region, 2'b00}, nv1, "protect outs");
    // volatile writes: immediate, locks untouched, reserved bits zero
    d = 8'($urandom) & 8'hFA;
    op(FSR_CMD_VOL_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_TWO, d);
    chk({7'h0, busy}, 8'h00, "volatile no busy");
    rchk(FSR_SEL_TWO, 8'hFF, d & FSR_S2_CFG_MASK, "vol two");
    chk({complement_map, quad_enable, 6'h0}, {d[6], d[1], 6'h0}, "two outs");
    v = 8'($urandom);
    op(FSR_CMD_VOL_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_THREE, v);
    rchk(FSR_SEL_THREE, 8'hFF, v & FSR_S3_VOL_MASK, "vol three");
    chk({pin_function_select, drive_strength, high_freq_mode, 2'b00, reset_pin_active, hold_active},
      {v[7:4], 2'b00, pins(d[1], v[7])}, "three outs");
    // software reset reloads volatile copies from non-volatile ones
    op(FSR_CMD_SW_RESET, 2'h0, 8'h00);
    rchk(FSR_SEL_ONE, 8'hFC, nv1, "reload one");
    rchk(FSR_SEL_TWO, 8'hFF, 8'h00, "reload two");
    rchk(FSR_SEL_THREE, 8'hFF, FSR_RESET_THREE, "reload three");
    // one-time lock bits
    op(FSR_CMD_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_TWO, 8'h38);
    wait_done(FSR_WRSR_CYC, FSR_WRSR_CYC - 2);
    chk({5'h0, security_lock}, 8'h07, "locks");
    // protect low with pin low blocks writes, pin high frees them
    op(FSR_CMD_VOL_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_ONE, nv1 | 8'h80);
    @(posedge clk);
    write_protect_n <= 1'b0;
    repeat (4) @(posedge clk);
    op(FSR_CMD_VOL_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_ONE, 8'h00);
    rchk(FSR_SEL_ONE, 8'hFC, nv1 | 8'h80, "pin locks");
    @(posedge clk);
    write_protect_n <= 1'b1;
    repeat (4) @(posedge clk);
    op(FSR_CMD_VOL_WREN, 2'h0, 8'h00);
    op(FSR_CMD_WRSR, FSR_SEL_ONE, nv1);
    rchk(FSR_SEL_ONE, 8'hFC, nv1, "pin frees");
    // program and erase: busy span, latch cleared at the end
    for (int i = 0; i < 2; i++) begin
      op(FSR_CMD_WREN, 2'h0, 8'h00);
      op(ops[i], 2'h0, 8'h00);
      chk({7'h0, busy}, 8'h01, "op busy");
      wait_done(cyc[i], cyc[i] - 2);
      rchk(FSR_SEL_ONE, 8'hFF, nv1, "op done");
    end
    // clock enable low freezes all state: the enable command is not taken
    @(posedge clk);
    ce <= 1'b0;
    op(FSR_CMD_WREN, 2'h0, 8'h00);
    chk({7'h0, acc}, 8'h00, "frozen refuse");
    rchk(FSR_SEL_ONE, 8'hFF, nv1, "frozen latch");
    @(posedge clk);
    ce <= 1'b1;
    // suspend flag
    op(FSR_CMD_SUSPEND, 2'h0, 8'h00);
    rchk(FSR_SEL_TWO, 8'hFF, 8'hB8, "suspended");
    op(FSR_CMD_RESUME, 2'h0, 8'h00);
    chk({7'h0, suspended_flag}, 8'h00, "resumed");
    results();
  end
endmodule

/* fsr_host_model.sv */
// host model: serial front end issuing decoded status commands to the bank
`timescale 1ns/1ps
module fsr_host_model (
  // clock
  input wire logic clk,
  // command strobe towards the register bank
  output logic cmd_valid,
  output fsr_pkg::fsr_cmd_t cmd,
  output logic [1:0] cmd_sel,
  output logic [7:0] cmd_wdata,
  // answers from the register bank
  input wire logic cmd_accepted,
  input wire logic busy
);
  import fsr_pkg::*;
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = FSR_CMD_NONE;
    cmd_sel = 2'h0;
    cmd_wdata = 8'h00;
  end
  // one command; the last enable command sent before a write picks the copy written
  task automatic issue(input fsr_cmd_t c, input logic [1:0] s, input logic [7:0] d, output logic acc);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_sel <= s;
    cmd_wdata <= d;
    @(negedge clk);
    acc = cmd_accepted;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd <= FSR_CMD_NONE;
    // stale data must not look valid after release
    cmd_wdata <= ~d;
  endtask
  // poll status until busy drops, bounded; nothing else is sent meanwhile
  task automatic poll_idle(input int max, output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < max) begin
      n++;
      @(negedge clk);
    end
  endtask
endmodule

/* fsr_op_timer.sv */
// down counter timing one embedded operation
`timescale 1ns/1ps
module fsr_op_timer #(
  parameter int CW = 12
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // load a length; abort drops it at once
  input wire logic load,
  input wire logic [CW-1:0] length,
  input wire logic abort,
  // one-cycle pulse when the count runs out
  output logic expired
);
  logic [CW-1:0] cnt_q; // cycles left
  logic [CW-1:0] cnt_d;
  logic exp_d;

  // the expiry compare needs at least two count bits
  initial begin
    if (CW < 2) begin
      $error("fsr_op_timer: CW must be at least 2");
    end
  end

  // next count; expiry when last cycle consumed
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (ce) begin
      if (abort) begin
        cnt_d = '0;
      end else if (load) begin
        cnt_d = length;
      end else if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;
        exp_d = (cnt_q == {{(CW-1){1'b0}}, 1'b1});
      end
    end
  end

  // register the count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = exp_d;
endmodule

/* fsr_pkg.sv */
// package: constants and types for the flash status/config register bank
package fsr_pkg;
  // register selectors on the command port
  localparam logic [1:0] FSR_SEL_ONE = 2'h0;
  localparam logic [1:0] FSR_SEL_TWO = 2'h1;
  localparam logic [1:0] FSR_SEL_THREE = 2'h2;
  // status register one bit positions
  localparam int FSR_S1_PROTECT_LO = 7;
  localparam int FSR_S1_GRANULARITY = 6;
  localparam int FSR_S1_DIRECTION = 5;
  localparam int FSR_S1_REGION_HI = 4;
  localparam int FSR_S1_REGION_LO = 2;
  localparam int FSR_S1_WEL = 1;
  localparam int FSR_S1_BUSY = 0;
  // status register two bit positions
  localparam int FSR_S2_SUSPEND = 7;
  localparam int FSR_S2_COMPLEMENT = 6;
  localparam int FSR_S2_LOCK_HI = 5;
  localparam int FSR_S2_LOCK_LO = 3;
  localparam int FSR_S2_QUAD = 1;
  localparam int FSR_S2_PROTECT_HI = 0;
  // status register three bit positions
  localparam int FSR_S3_PIN_FUNC = 7;
  localparam int FSR_S3_DRIVE_HI = 6;
  localparam int FSR_S3_DRIVE_LO = 5;
  localparam int FSR_S3_HFM = 4;
  // writable masks: bits kept in volatile and non-volatile form; FSR_S3_VOL_MASK adds volatile-only bits
  localparam logic [7:0] FSR_S1_CFG_MASK = 8'hFC;
  localparam logic [7:0] FSR_S2_CFG_MASK = 8'h43;
  localparam logic [7:0] FSR_S2_LOCK_MASK = 8'h38;
  localparam logic [7:0] FSR_S3_NV_MASK = 8'h90;
  localparam logic [7:0] FSR_S3_VOL_MASK = 8'hF0;
  // reset values of every register copy
  localparam logic [7:0] FSR_RESET_ONE = 8'h00;
  localparam logic [7:0] FSR_RESET_TWO = 8'h00;
  localparam logic [7:0] FSR_RESET_THREE = 8'h00;
  // embedded operation times (ns) and derived cycle counts at 20 MHz
  localparam int FSR_CLK_NS = 50;
  localparam int FSR_T_WRSR_NS = 5000;
  localparam int FSR_T_PROG_NS = 20000;
  localparam int FSR_T_ERASE_NS = 100000;
  localparam int FSR_WRSR_CYC = (FSR_T_WRSR_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
  localparam int FSR_PROG_CYC = (FSR_T_PROG_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
  localparam int FSR_ERASE_CYC = (FSR_T_ERASE_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
  // decoded commands coming from the serial front end
  typedef enum logic [3:0] {
    FSR_CMD_NONE = 4'h0,
    FSR_CMD_WREN = 4'h1,
    FSR_CMD_WRDI = 4'h2,
    FSR_CMD_VOL_WREN = 4'h3,
    FSR_CMD_WRSR = 4'h4,
    FSR_CMD_PROG = 4'h5,
    FSR_CMD_ERASE = 4'h6,
    FSR_CMD_SUSPEND = 4'h7,
    FSR_CMD_RESUME = 4'h8,
    FSR_CMD_SW_RESET = 4'h9,
    FSR_CMD_RDSR = 4'hA
  } fsr_cmd_t;
  // embedded operation sequencer states, gray along idle-run-done
  typedef enum logic [1:0] {
    FSR_ST_IDLE = 2'b00,
    FSR_ST_RUN = 2'b01,
    FSR_ST_DONE = 2'b11
  } fsr_state_t;
endpackage

/* fsr_regs.sv */
// flash status and configuration register bank with embedded-op sequencer
// Overview of operation
// - status one bit 7: status protect low
// - status one bit 6: sector/block granularity
// - status one bit 5: top/bottom direction
// - status one bits 4:2: region field, zero unprotected
// - write enable latch gates embedded operations
// - status one bit 0: busy flag
// - status two bit 7: suspended flag
// - status two bit 6: complement map select
// - status two bits 5:3: OTP security locks
// - quad enable disables protect/hold pin functions
// - status two bit 0: status protect high
// - status three bit 7: hold or reset pin
// - status three bits 6:5: volatile drive strength
// - status three bit 4: high frequency mode
// - busy set during program, erase, non-volatile status write
// - while busy ignore all but status read
// - busy clears when operation finishes
// - only write enable sets the latch
// - latch cleared by reset, disable, operations
// - all bits default to zero
// - volatile and non-volatile copies, volatile governs
// - software reset loads volatile copies from non-volatile
// - volatile-enable write touches volatile copies only
// - latch cleared when embedded operation completes
`timescale 1ns/1ps
module fsr_regs
  import fsr_pkg::*;
#(
  parameter int CW = 12,
  parameter logic [7:0] FACTORY_THREE = fsr_pkg::FSR_RESET_THREE
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // decoded command strobe from the serial front end
  input wire logic cmd_valid,
  input wire fsr_pkg::fsr_cmd_t cmd,
  input wire logic [1:0] cmd_sel,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_accepted,
  // register read port
  input wire logic [1:0] rd_sel,
  output logic [7:0] rd_data,
  // write protect pin (asynchronous)
  input wire logic write_protect_n,
  // configuration outputs to the array and pad logic
  output logic [2:0] region,
  output logic granularity_select,
  output logic protect_direction,
  output logic complement_map,
  output logic [2:0] security_lock,
  output logic quad_enable,
  output logic pin_function_select,
  output logic hold_active,
  output logic reset_pin_active,
  output logic [1:0] drive_strength,
  output logic high_freq_mode,
  output logic busy,
  output logic suspended_flag
);
  import fsr_pkg::*;

  initial begin
    if (CW < 2 || (1 << CW) <= FSR_ERASE_CYC) begin
      $error("fsr_regs: CW too small for operation lengths");
    end
  end

  localparam logic [CW-1:0] WRSR_LEN = CW'(FSR_WRSR_CYC);
  localparam logic [CW-1:0] PROG_LEN = CW'(FSR_PROG_CYC);
  localparam logic [CW-1:0] ERASE_LEN = CW'(FSR_ERASE_CYC);

  // volatile copies govern behaviour; non-volatile copies hold the reload value
  logic [7:0] vol1_q, vol1_d;
  logic [7:0] vol2_q, vol2_d;
  logic [7:0] vol3_q, vol3_d;
  logic [7:0] nv1_q, nv1_d;
  logic [7:0] nv2_q, nv2_d;
  logic [7:0] nv3_q, nv3_d;
  logic wel_q, wel_d; // write enable latch
  logic vwel_q, vwel_d; // volatile write enable armed
  logic sus_q, sus_d; // suspended
  fsr_state_t st_q, st_d; // embedded op sequencer
  logic wrsr_nv_q, wrsr_nv_d; // status write in flight targets nv copy
  logic [1:0] pend_sel_q, pend_sel_d;
  logic [7:0] pend_data_q, pend_data_d;
  // timer control
  logic t_load;
  logic [CW-1:0] t_len;
  logic t_abort;
  logic t_exp;
  logic wp_sync; // synchronised write protect pin
  logic sr_locked; // status registers locked by protect bits and pin
  logic is_busy;

  fsr_sync #(.WIDTH(1)) u_wp_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(write_protect_n),
    .sync_out(wp_sync)
  );

  fsr_op_timer #(.CW(CW)) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(t_load),
    .length(t_len),
    .abort(t_abort),
    .expired(t_exp)
  );

  assign is_busy = (st_q != FSR_ST_IDLE);

  // protect-bit lock: pin guards only with quad off; lock-down modes always lock
  always_comb begin
    sr_locked = 1'b0;
    if (vol2_q[FSR_S2_PROTECT_HI]) begin
      sr_locked = 1'b1; // supply or OTP lock-down
    end else if (vol1_q[FSR_S1_PROTECT_LO] && !vol2_q[FSR_S2_QUAD] && !wp_sync) begin
      sr_locked = 1'b1; // pin guards registers
    end
  end

  // command handling and sequencer next state
  always_comb begin
    vol1_d = vol1_q;
    vol2_d = vol2_q;
    vol3_d = vol3_q;
    nv1_d = nv1_q;
    nv2_d = nv2_q;
    nv3_d = nv3_q;
    wel_d = wel_q;
    vwel_d = vwel_q;
    sus_d = sus_q;
    st_d = st_q;
    wrsr_nv_d = wrsr_nv_q;
    pend_sel_d = pend_sel_q;
    pend_data_d = pend_data_q;
    t_load = 1'b0;
    t_len = '0;
    t_abort = 1'b0;
    cmd_accepted = 1'b0;
    if (ce) begin
      // sequencer progression
      unique case (st_q)
        FSR_ST_IDLE: begin
        end
        FSR_ST_RUN: begin
          if (t_exp) begin
            st_d = FSR_ST_DONE;
          end
        end
        FSR_ST_DONE: begin
          st_d = FSR_ST_IDLE;
          wel_d = 1'b0;
          if (pend_sel_q == FSR_SEL_ONE) begin
            nv1_d = (nv1_q & ~FSR_S1_CFG_MASK) | (pend_data_q & FSR_S1_CFG_MASK);
          end else if (pend_sel_q == FSR_SEL_TWO) begin
            nv2_d = (nv2_q & ~FSR_S2_CFG_MASK) | (pend_data_q & FSR_S2_CFG_MASK);
            nv2_d = nv2_d | (pend_data_q & FSR_S2_LOCK_MASK); // OTP only sets
          end else if (pend_sel_q == FSR_SEL_THREE) begin
            nv3_d = (nv3_q & ~FSR_S3_NV_MASK) | (pend_data_q & FSR_S3_NV_MASK);
          end
          if (wrsr_nv_q) begin
            // the new setting also takes effect in the governing copy
            vol1_d = (vol1_q & ~FSR_S1_CFG_MASK) | (nv1_d & FSR_S1_CFG_MASK);
            vol2_d = (vol2_q & ~(FSR_S2_CFG_MASK | FSR_S2_LOCK_MASK))
              | (nv2_d & (FSR_S2_CFG_MASK | FSR_S2_LOCK_MASK));
            vol3_d = (vol3_q & ~FSR_S3_NV_MASK) | (nv3_d & FSR_S3_NV_MASK);
          end
          wrsr_nv_d = 1'b0;
        end
        default: begin
          st_d = FSR_ST_IDLE; // illegal code recovers to idle
        end
      endcase
      // commands; while busy only the status read is honoured
      if (cmd_valid && cmd == FSR_CMD_SW_RESET && !is_busy) begin
        cmd_accepted = 1'b1;
        vol1_d = nv1_q & FSR_S1_CFG_MASK;
        vol2_d = nv2_q & (FSR_S2_CFG_MASK | FSR_S2_LOCK_MASK);
        vol3_d = (nv3_q & FSR_S3_NV_MASK) | (FACTORY_THREE & ~FSR_S3_NV_MASK);
        if (nv2_q[FSR_S2_PROTECT_HI] && !nv1_q[FSR_S1_PROTECT_LO]) begin
          vol2_d[FSR_S2_PROTECT_HI] = 1'b0; // supply lock-down ends at reset
        end
        wel_d = 1'b0;
        vwel_d = 1'b0;
        sus_d = 1'b0;
      end else if (cmd_valid && cmd == FSR_CMD_RDSR) begin
        cmd_accepted = 1'b1;
      end else if (cmd_valid && !is_busy) begin
        cmd_accepted = 1'b1;
        unique case (cmd)
          FSR_CMD_WREN: begin
            wel_d = 1'b1;
            vwel_d = 1'b0;
          end
          FSR_CMD_WRDI: begin
            wel_d = 1'b0;
            vwel_d = 1'b0;
          end
          FSR_CMD_VOL_WREN: begin
            vwel_d = 1'b1;
          end
          FSR_CMD_SUSPEND: begin
            sus_d = 1'b1;
          end
          FSR_CMD_RESUME: begin
            sus_d = 1'b0;
          end
          FSR_CMD_PROG, FSR_CMD_ERASE: begin
            if (wel_q) begin
              st_d = FSR_ST_RUN;
              t_load = 1'b1;
              t_len = (cmd == FSR_CMD_PROG) ? PROG_LEN : ERASE_LEN;
              pend_sel_d = 2'h3; // no register to commit
            end
          end
          FSR_CMD_WRSR: begin
            if (vwel_q && !(sr_locked && cmd_sel != FSR_SEL_THREE)) begin
              // volatile write: immediate, no busy, nv untouched
              vwel_d = 1'b0;
              if (cmd_sel == FSR_SEL_ONE) begin
                vol1_d = (vol1_q & ~FSR_S1_CFG_MASK) | (cmd_wdata & FSR_S1_CFG_MASK);
              end else if (cmd_sel == FSR_SEL_TWO) begin
                vol2_d = (vol2_q & ~FSR_S2_CFG_MASK) | (cmd_wdata & FSR_S2_CFG_MASK);
              end else if (cmd_sel == FSR_SEL_THREE) begin
                vol3_d = cmd_wdata & FSR_S3_VOL_MASK;
              end
            end else if (wel_q && !(sr_locked && cmd_sel != FSR_SEL_THREE)) begin
              st_d = FSR_ST_RUN;
              t_load = 1'b1;
              t_len = WRSR_LEN;
              wrsr_nv_d = 1'b1;
              pend_sel_d = cmd_sel;
              pend_data_d = cmd_wdata;
            end else begin
              wel_d = 1'b0; // refused write still disables
              vwel_d = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // registers; reset returns nv copies to their defaults along with the volatile ones
  always_ff @(posedge clk) begin
    if (rst) begin
      vol1_q <= FSR_RESET_ONE;
      vol2_q <= FSR_RESET_TWO;
      vol3_q <= FSR_RESET_THREE;
      nv1_q <= FSR_RESET_ONE;
      nv2_q <= FSR_RESET_TWO;
      nv3_q <= FSR_RESET_THREE;
      wel_q <= 1'b0;
      vwel_q <= 1'b0;
      sus_q <= 1'b0;
      st_q <= FSR_ST_IDLE;
      wrsr_nv_q <= 1'b0;
      pend_sel_q <= 2'h3;
      pend_data_q <= 8'h00;
    end else begin
      vol1_q <= vol1_d;
      vol2_q <= vol2_d;
      vol3_q <= vol3_d;
      nv1_q <= nv1_d;
      nv2_q <= nv2_d;
      nv3_q <= nv3_d;
      wel_q <= wel_d;
      vwel_q <= vwel_d;
      sus_q <= sus_d;
      st_q <= st_d;
      wrsr_nv_q <= wrsr_nv_d;
      pend_sel_q <= pend_sel_d;
      pend_data_q <= pend_data_d;
    end
  end

  // factory defaults for pin function and drive strength applied on release
  // are not modelled at reset: FACTORY_THREE sets the bits outside FSR_S3_NV_MASK at software reset

  // read mux; reserved bits come back as zero
  always_comb begin
    unique case (rd_sel)
      FSR_SEL_ONE: rd_data = (vol1_q & FSR_S1_CFG_MASK)
        | {6'h00, wel_q, is_busy};
      FSR_SEL_TWO: rd_data = {sus_q, vol2_q[6:0] & 7'h7B};
      FSR_SEL_THREE: rd_data = vol3_q & FSR_S3_VOL_MASK;
      default: rd_data = 8'h00;
    endcase
  end

  // configuration drawn from the volatile copies
  assign region = vol1_q[FSR_S1_REGION_HI:FSR_S1_REGION_LO];
  assign granularity_select = vol1_q[FSR_S1_GRANULARITY];
  assign protect_direction = vol1_q[FSR_S1_DIRECTION];
  assign complement_map = vol2_q[FSR_S2_COMPLEMENT];
  assign security_lock = vol2_q[FSR_S2_LOCK_HI:FSR_S2_LOCK_LO];
  assign quad_enable = vol2_q[FSR_S2_QUAD];
  assign pin_function_select = vol3_q[FSR_S3_PIN_FUNC];
  assign hold_active = !quad_enable && !pin_function_select;
  assign reset_pin_active = !quad_enable && pin_function_select;
  assign drive_strength = vol3_q[FSR_S3_DRIVE_HI:FSR_S3_DRIVE_LO];
  assign high_freq_mode = vol3_q[FSR_S3_HFM];
  assign busy = is_busy;
  assign suspended_flag = sus_q;

  // busy holds for at least 8 cycles after a status write starts
  a_busy_wrsr_len: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q == FSR_ST_IDLE && st_d == FSR_ST_RUN && t_len == WRSR_LEN)
    |=> busy [*8])
    else $error("busy dropped early after status write");
  // leaving busy clears the latch
  a_wel_cleared: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) |-> !wel_q)
    else $error("write enable latch still set after operation");
  // only write enable raises the latch
  a_wel_source: assert property (@(posedge clk) disable iff (rst)
    $rose(wel_q) |-> $past(cmd_valid && cmd == FSR_CMD_WREN && ce))
    else $error("latch set without write enable command");
  // nothing but a status read is taken while busy
  a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    (busy && cmd_valid && cmd != FSR_CMD_RDSR) |-> !cmd_accepted)
    else $error("command accepted while busy");
  // no operation starts without the latch
  a_wel_gates: assert property (@(posedge clk) disable iff (rst)
    $rose(busy) |-> $past(wel_q))
    else $error("embedded operation started without latch");
  // reserved bits read zero
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_sel == FSR_SEL_THREE |-> rd_data[3:0] == 4'h0)
    and (rd_sel == FSR_SEL_TWO |-> rd_data[2] == 1'b0))
    else $error("reserved bit reads nonzero");
  // volatile write leaves non-volatile copy alone
  a_vol_only: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_valid && !busy && cmd == FSR_CMD_WRSR && vwel_q) |=> $stable(nv1_q) && !busy)
    else $error("volatile write disturbed non-volatile copy");
  // pin functions gated by quad enable
  a_quad_pins: assert property (@(posedge clk) disable iff (rst)
    quad_enable |-> !hold_active && !reset_pin_active)
    else $error("pin function active in quad mode");
endmodule

/* fsr_sync.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module fsr_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values: shift one stage
  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (ce) begin
      meta_d = async_in;
      sync_d = meta_q;
    end
  end

  // registers; reset chosen as inactive high pin level
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
